// ---- core/sasm_pkg.sv ----
// Overview of operation
// - Conversion clock divides system clock by 1..16
// - One of four start sources starts conversion
// - Busy bit high for whole conversion
// - Busy falling edge at completion, not on abort, sets done, requests interrupt
// - Result left or right aligned by justify
// - Track mode zero: track except while converting
// - Track mode one: software start tracks three SAR clocks first
// - Track mode one: Timer 3 start tracks three SAR clocks
// - Track mode one: external mode tracks only while pin low
// - Track mode one: Timer 2 start tracks three SAR clocks
// - Tracking shut down during chip standby
// - Pair bit one makes even-positive differential pair
// - Upper four mux register bits read zero
// - Differential results two's complement, single-ended unsigned
// - Channel codes pick input, pair or temperature
// - All pairs single-ended after reset
// - Converter active only while enable bit set
// - Source codes 00 sw, 01 T3, 10 ext, 11 T2
// - Done flag sticky, cleared only by software
package sasm_pkg;
    // Special function register addresses
    localparam logic [7:0] ADDR_PAIR_CFG = 8'hBA;
    localparam logic [7:0] ADDR_CHAN_SEL = 8'hBB;
    localparam logic [7:0] ADDR_CONV_CFG = 8'hBC;
    localparam logic [7:0] ADDR_RES_LOW = 8'hBE;
    localparam logic [7:0] ADDR_RES_HIGH = 8'hBF;
    localparam logic [7:0] ADDR_CONV_CTL = 8'hE8;
    // Reset values
    localparam logic [7:0] CFG_RESET = 8'h60;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] MUX_RESET = 8'h00;
    // Control register fields
    localparam int CTL_EN = 7;
    localparam int CTL_TM = 6;
    localparam int CTL_DONE = 5;
    localparam int CTL_BUSY = 4;
    localparam int CTL_SRC_HI = 3;
    localparam int CTL_SRC_LO = 2;
    localparam int CTL_WIN = 1;
    localparam int CTL_LJ = 0;
    // Configuration register fields; bits 4-3 unused
    localparam int CFG_SCALE_HI = 7;
    localparam int CFG_SCALE_LO = 5;
    localparam int CFG_GAIN_HI = 2;
    localparam logic [7:0] CFG_MASK = 8'hE7;
    // Mux registers keep only the low nibble
    localparam logic [7:0] MUX_MASK = 8'h0F;
    // Start source encodings
    localparam logic [1:0] SRC_SW = 2'h0;
    localparam logic [1:0] SRC_T3 = 2'h1;
    localparam logic [1:0] SRC_EXT = 2'h2;
    localparam logic [1:0] SRC_T2 = 2'h3;
    // Low-power track window in SAR clocks
    localparam logic [1:0] TRACK_CLOCKS = 2'h3;
    // Temperature sensor mux code
    localparam logic [3:0] MUX_TEMP = 4'h8;
endpackage : sasm_pkg

// ---- core/sasm_clk_div.sv ----
`timescale 1ns/1ps
// SAR clock enable derived from the system clock
module sasm_clk_div (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [2:0] scale,
    output logic sar_tick
);
    logic [3:0] div_cnt; // Cycles since last tick

    // Terminal count: 0,1,3,7, then 15 for any 1xx code
    function automatic logic [3:0] sasm_limit(input logic [2:0] s);
        case (s)
            3'h0: sasm_limit = 4'h0;
            3'h1: sasm_limit = 4'h1;
            3'h2: sasm_limit = 4'h3;
            3'h3: sasm_limit = 4'h7;
            default: sasm_limit = 4'hF;
        endcase
    endfunction : sasm_limit

    // Free-running divider; >= so a smaller scale never overruns
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            div_cnt <= 4'h0;
            sar_tick <= 1'b0;
        end else if (div_cnt >= sasm_limit(scale)) begin
            div_cnt <= 4'h0;
            sar_tick <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 4'h1;
            sar_tick <= 1'b0;
        end
    end
endmodule : sasm_clk_div

// ---- core/sasm_amux_decode.sv ----
`timescale 1ns/1ps
// Analog multiplexer channel decode
module sasm_amux_decode (
    input wire logic [3:0] pair_cfg,
    input wire logic [3:0] chan_sel,
    output logic [3:0] pos_sel,
    output logic [2:0] neg_sel,
    output logic diff,
    output logic temp
);
    // Pure decode; the top registers the results
    always_comb begin
        pos_sel = chan_sel;
        neg_sel = 3'h0;
        diff = 1'b0;
        temp = chan_sel[3];
        if (chan_sel[3]) begin
            pos_sel = sasm_pkg::MUX_TEMP;
        end else if (pair_cfg[chan_sel[2:1]]) begin
            // Even input positive, odd negative; odd code alike
            pos_sel = {1'b0, chan_sel[2:1], 1'b0};
            neg_sel = {chan_sel[2:1], 1'b1};
            diff = 1'b1;
        end
    end
endmodule : sasm_amux_decode

// ---- core/sasm_top.sv ----
`timescale 1ns/1ps
// Sequencer around a successive-approximation converter
module sasm_top #(
    parameter int CONV_CLOCKS = 16 // SAR clocks of bit decisions
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    input wire logic timer2_ovf,
    input wire logic timer3_ovf,
    input wire logic ext_convert_start,
    input wire logic chip_standby,
    input wire logic irq_enable,
    input wire logic [11:0] core_result,
    output logic conv_irq,
    output logic sar_clk_en,
    output logic track_on,
    output logic hold_convert,
    output logic converter_enable,
    output logic [2:0] pga_gain,
    output logic [3:0] amux_pos,
    output logic [2:0] amux_neg,
    output logic amux_diff,
    output logic amux_temp
);
    typedef enum logic [1:0] {
        SASM_IDLE,
        SASM_TRACK,
        SASM_CONV
    } sasm_state_t;

    sasm_state_t st; // Sequencer state
    sasm_state_t next_st; // Next sequencer state
    logic [7:0] converter_config_reg; // Scale and gain
    logic [7:0] converter_control_reg; // Stored control bits
    logic [7:0] input_pair_config; // Pair modes, low nibble
    logic [7:0] channel_select; // Channel code, low nibble
    logic [7:0] result_high; // Justified result, upper byte
    logic [7:0] result_low; // Justified result, lower byte
    logic conversion_done_flag; // Sticky completion flag
    logic conversion_busy; // Busy view of the sequencer
    logic [7:0] conv_cnt; // SAR clocks spent converting
    logic [1:0] trk_cnt; // SAR clocks spent tracking
    logic ext_q; // Previous pin level
    logic ext_rise; // Rising edge on the pin
    logic sar_tick; // One SAR clock period elapsed
    logic start_req; // Selected source fired
    logic wr_ctl; // Write to control register
    logic sw_start; // Software start strobe
    logic busy_fall; // Conversion just ended
    logic next_track; // Next tracking level
    logic en; // Converter enable bit
    logic tm; // Low-power track mode bit
    logic [1:0] src; // Start source field
    logic [3:0] dec_pos; // Decoded positive input
    logic [2:0] dec_neg; // Decoded negative input
    logic dec_diff; // Decoded differential flag
    logic dec_temp; // Decoded temperature select

    // Named fields of the control register
    assign en = converter_control_reg[sasm_pkg::CTL_EN];
    assign tm = converter_control_reg[sasm_pkg::CTL_TM];
    assign src = converter_control_reg[sasm_pkg::CTL_SRC_HI:
                                       sasm_pkg::CTL_SRC_LO];
    assign wr_ctl = sfr_wr && (sfr_addr == sasm_pkg::ADDR_CONV_CTL);
    assign sw_start = wr_ctl && sfr_wdata[sasm_pkg::CTL_BUSY];
    assign conversion_busy = (st != SASM_IDLE);
    // An abort by clearing enable is not a completion: no done, no result
    assign busy_fall = (st == SASM_CONV) && (next_st == SASM_IDLE)
        && en;
    assign converter_enable = en;

    // SAR clock enable from the programmable divider
    sasm_clk_div u_div (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .scale(converter_config_reg[sasm_pkg::CFG_SCALE_HI:
                                    sasm_pkg::CFG_SCALE_LO]),
        .sar_tick(sar_tick)
    );
    assign sar_clk_en = sar_tick;

    // Multiplexer decode from the two mux registers
    sasm_amux_decode u_amux (
        .pair_cfg(input_pair_config[3:0]),
        .chan_sel(channel_select[3:0]),
        .pos_sel(dec_pos),
        .neg_sel(dec_neg),
        .diff(dec_diff),
        .temp(dec_temp)
    );

    // Pin is synchronous already; one flop finds the edge
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ext_q <= ext_convert_start; // Pin high in reset is no edge
        end else begin
            ext_q <= ext_convert_start;
        end
    end
    assign ext_rise = ext_convert_start && !ext_q;

    // Exactly one source counts; the others are ignored
    always_comb begin
        case (src)
            sasm_pkg::SRC_SW: start_req = sw_start;
            sasm_pkg::SRC_T3: start_req = timer3_ovf;
            sasm_pkg::SRC_EXT: start_req = ext_rise;
            default: start_req = timer2_ovf;
        endcase
    end

    // Sequencer: triggers while busy are dropped, not queued
    always_comb begin
        next_st = st;
        case (st)
            SASM_IDLE: begin
                if (en && start_req) begin
                    // Low-power mode needs a fresh track window,
                    // except the pin mode which tracked while low
                    if (tm && src != sasm_pkg::SRC_EXT) begin
                        next_st = SASM_TRACK;
                    end else begin
                        next_st = SASM_CONV;
                    end
                end
            end
            SASM_TRACK: begin
                if (sar_tick && trk_cnt == sasm_pkg::TRACK_CLOCKS
                        - 2'h1) begin
                    next_st = SASM_CONV;
                end
            end
            default: begin
                if (sar_tick && conv_cnt == 8'(CONV_CLOCKS - 1)) begin
                    next_st = SASM_IDLE;
                end
            end
        endcase
        if (!en) begin
            next_st = SASM_IDLE;
        end
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st <= SASM_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // SAR clock counters for the track and convert phases
    always_ff @(posedge ref_clk) begin
        if (sys_rst || st == SASM_IDLE) begin
            trk_cnt <= 2'h0;
            conv_cnt <= 8'h0;
        end else if (sar_tick && st == SASM_TRACK) begin
            trk_cnt <= trk_cnt + 2'h1;
        end else if (sar_tick && st == SASM_CONV) begin
            conv_cnt <= conv_cnt + 8'h1;
        end
    end

    // Track-and-hold control; standby overrides every mode
    always_comb begin
        if (!en || chip_standby) begin
            next_track = 1'b0;
        end else if (!tm) begin
            next_track = (next_st != SASM_CONV);
        end else if (src == sasm_pkg::SRC_EXT) begin
            // Held in low power while the pin is high
            next_track = !ext_convert_start
                && next_st == SASM_IDLE;
        end else begin
            next_track = (next_st == SASM_TRACK);
        end
    end

    // Analog-facing outputs from flops
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            track_on <= 1'b0;
            hold_convert <= 1'b0;
            amux_pos <= 4'h0;
            amux_neg <= 3'h0;
            amux_diff <= 1'b0;
            amux_temp <= 1'b0;
        end else begin
            track_on <= next_track;
            hold_convert <= (next_st == SASM_CONV);
            amux_pos <= dec_pos;
            amux_neg <= dec_neg;
            amux_diff <= dec_diff;
            amux_temp <= dec_temp;
        end
    end
    assign pga_gain = converter_config_reg[sasm_pkg::CFG_GAIN_HI:0];

    // Configuration and mux registers; unused bits never stored
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            converter_config_reg <= sasm_pkg::CFG_RESET;
            input_pair_config <= sasm_pkg::MUX_RESET;
            channel_select <= sasm_pkg::MUX_RESET;
        end else if (sfr_wr) begin
            if (sfr_addr == sasm_pkg::ADDR_CONV_CFG) begin
                converter_config_reg <= sfr_wdata & sasm_pkg::CFG_MASK;
            end else if (sfr_addr == sasm_pkg::ADDR_PAIR_CFG) begin
                input_pair_config <= sfr_wdata & sasm_pkg::MUX_MASK;
            end else if (sfr_addr == sasm_pkg::ADDR_CHAN_SEL) begin
                channel_select <= sfr_wdata & sasm_pkg::MUX_MASK;
            end
        end
    end

    // Control register; busy bit is never stored, it is the state
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            converter_control_reg <= sasm_pkg::CTL_RESET;
        end else if (wr_ctl) begin
            converter_control_reg <= sfr_wdata
                & ~(8'h1 << sasm_pkg::CTL_BUSY);
        end
    end

    // Done flag: completion beats a same-cycle software clear
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            conversion_done_flag <= 1'b0;
        end else if (busy_fall) begin
            conversion_done_flag <= 1'b1;
        end else if (wr_ctl) begin
            conversion_done_flag <= sfr_wdata[sasm_pkg::CTL_DONE];
        end
    end

    // Interrupt request pulse on each completion when enabled
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            conv_irq <= 1'b0;
        end else begin
            conv_irq <= busy_fall && irq_enable;
        end
    end

    // Result capture; sign extension only for differential inputs
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            result_high <= 8'h00;
            result_low <= 8'h00;
        end else if (busy_fall) begin
            if (converter_control_reg[sasm_pkg::CTL_LJ]) begin
                result_high <= core_result[11:4];
                result_low <= {core_result[3:0], 4'h0};
            end else begin
                result_high <= {{4{amux_diff && core_result[11]}},
                                core_result[11:8]};
                result_low <= core_result[7:0];
            end
        end
    end

    // Read port: one cycle latency, unmapped addresses read zero
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            if (sfr_addr == sasm_pkg::ADDR_CONV_CTL) begin
                sfr_rdata <= {converter_control_reg[7:6],
                              conversion_done_flag, conversion_busy,
                              converter_control_reg[3:0]};
            end else if (sfr_addr == sasm_pkg::ADDR_CONV_CFG) begin
                sfr_rdata <= converter_config_reg;
            end else if (sfr_addr == sasm_pkg::ADDR_PAIR_CFG) begin
                sfr_rdata <= input_pair_config;
            end else if (sfr_addr == sasm_pkg::ADDR_CHAN_SEL) begin
                sfr_rdata <= channel_select;
            end else if (sfr_addr == sasm_pkg::ADDR_RES_HIGH) begin
                sfr_rdata <= result_high;
            end else if (sfr_addr == sasm_pkg::ADDR_RES_LOW) begin
                sfr_rdata <= result_low;
            end else begin
                sfr_rdata <= 8'h00;
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // Software start in low-power mode, then one cycle of tracking and a non-idle state
    sequence s_sw_lp_start;
        st == SASM_IDLE && en && tm && src == sasm_pkg::SRC_SW
            && sw_start;
    endsequence
    sequence s_track_phase;
        st == SASM_TRACK [*1] ##1 st != SASM_IDLE;
    endsequence

    AST_SW_TRACK: assert property (s_sw_lp_start |=> s_track_phase)
        else $error("software start did not enter tracking");
    AST_TRACK_LEN: assert property ($rose(st == SASM_CONV) && tm
            && src != sasm_pkg::SRC_EXT && en
            |-> $past(trk_cnt) == 2'h2 && $past(sar_tick))
        else $error("track window not three SAR clocks");
    AST_EXT_START: assert property (st == SASM_IDLE && en
            && src == sasm_pkg::SRC_EXT && ext_rise
            |=> st == SASM_CONV && hold_convert)
        else $error("pin edge did not start conversion");
    AST_NO_START: assert property (st == SASM_IDLE && !start_req
            |=> st == SASM_IDLE)
        else $error("conversion started without its source");
    // Flag and interrupt pulse both appear the cycle busy reads low
    AST_DONE_SET: assert property ($fell(conversion_busy)
            && $past(en) |-> conversion_done_flag
            && conv_irq == $past(irq_enable))
        else $error("completion flag or interrupt missing");
    AST_DONE_STICKY: assert property (conversion_done_flag
            && !(wr_ctl && !sfr_wdata[sasm_pkg::CTL_DONE])
            |=> conversion_done_flag)
        else $error("done flag lost without a software clear");
    AST_MUX_UPPER: assert property (sfr_rd
            && (sfr_addr == sasm_pkg::ADDR_PAIR_CFG
            || sfr_addr == sasm_pkg::ADDR_CHAN_SEL)
            |=> sfr_rdata[7:4] == 4'h0)
        else $error("mux register upper bits not zero");
    AST_DISABLED: assert property (!en |=> !conversion_busy
            && !track_on)
        else $error("converter active while disabled");
    AST_STANDBY: assert property (chip_standby |=> !track_on)
        else $error("tracking during chip standby");
    AST_BUSY_HOLD: assert property (st == SASM_CONV && !sar_tick && en
            |=> conversion_busy)
        else $error("busy dropped mid conversion");
endmodule : sasm_top

// ---- verification/sasm_partner.sv ----
`timescale 1ns/1ps
// Far side of the sequencer: two timers, the convert-start pin and the core
module sasm_partner #(
    parameter int MIN_GAP = 4 // Fewest cycles between two timer overflows
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic fire_t2,
    input wire logic fire_t3,
    input wire logic ext_lvl,
    input wire logic [11:0] code,
    output logic timer2_ovf,
    output logic timer3_ovf,
    output logic ext_convert_start,
    output logic [11:0] core_result
);
    int gap; // Cycles since the last overflow request

    // Overflows are one-cycle pulses; a request inside the gap is dropped,
    // so two overflows always have at least MIN_GAP cycles between them
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            gap <= MIN_GAP;
            timer2_ovf <= 1'b0;
            timer3_ovf <= 1'b0;
        end else begin
            timer2_ovf <= fire_t2 && (gap >= MIN_GAP);
            timer3_ovf <= fire_t3 && (gap >= MIN_GAP);
            gap <= (fire_t2 || fire_t3) ? 0 : gap + 1;
        end
    end

    // Pin follows the requested level one cycle late, like a board driver
    always_ff @(posedge ref_clk) begin
        ext_convert_start <= sys_rst ? 1'b0 : ext_lvl;
    end

    // Core code is held steady; the sequencer samples it at conversion end
    assign core_result = code;
endmodule : sasm_partner

// ---- verification/sasm_top_tb.sv ----
`timescale 1ns/1ps
`define CHK(a, e) begin \
    n_tests++; \
    if ((a) !== (e)) begin \
        bad_count++; \
        $display("MISMATCH at %0t: got %h, expected %h", $time, a, e); \
    end \
end
// Register-level bench for the converter sequencer
module sasm_top_tb;
    logic ref_clk;
    logic sys_rst = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_rdata;
    logic timer2_ovf, timer3_ovf, ext_convert_start;
    logic fire_t2 = 1'b0; // Ask the model for a Timer 2 overflow
    logic fire_t3 = 1'b0; // Ask the model for a Timer 3 overflow
    logic ext_lvl = 1'b0; // Requested convert-start pin level
    logic chip_standby = 1'b0;
    logic irq_enable = 1'b0;
    logic [11:0] core_result;
    logic conv_irq, sar_clk_en, track_on, hold_convert, converter_enable;
    logic [2:0] pga_gain;
    logic [3:0] amux_pos;
    logic [2:0] amux_neg;
    logic amux_diff, amux_temp;
    int bad_count = 0;
    int n_tests = 0;
    int irq_seen = 0; // Interrupt pulses seen on the output

    // Short conversions keep the run brief; timing checks use this figure
    sasm_top #(.CONV_CLOCKS(2)) uut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .timer2_ovf(timer2_ovf),
        .timer3_ovf(timer3_ovf), .ext_convert_start(ext_convert_start),
        .chip_standby(chip_standby), .irq_enable(irq_enable),
        .core_result(core_result), .conv_irq(conv_irq),
        .sar_clk_en(sar_clk_en), .track_on(track_on),
        .hold_convert(hold_convert), .converter_enable(converter_enable),
        .pga_gain(pga_gain), .amux_pos(amux_pos), .amux_neg(amux_neg),
        .amux_diff(amux_diff), .amux_temp(amux_temp));

    sasm_partner far_side (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .fire_t2(fire_t2), .fire_t3(fire_t3), .ext_lvl(ext_lvl),
        .code(12'hA5C), .timer2_ovf(timer2_ovf), .timer3_ovf(timer3_ovf),
        .ext_convert_start(ext_convert_start), .core_result(core_result));

    // 50 MHz system clock
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // Count every interrupt pulse; each stands for one cycle only
    always @(posedge ref_clk) begin
        if (conv_irq === 1'b1) irq_seen++;
    end

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    // One register write: strobe stands one cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge ref_clk);
        sfr_wr <= 1'b0;
    endtask : wr

    // One register read: data is registered, settled just after the edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge ref_clk);
        sfr_rd <= 1'b0;
        #1;
        d = sfr_rdata;
    endtask : rd

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        `CHK(d, e)
    endtask : rchk

    // Fire one start source; returns at the edge where the design takes it
    task automatic trig(input logic [1:0] s, input logic [7:0] ctl);
        if (s == sasm_pkg::SRC_SW) begin
            wr(sasm_pkg::ADDR_CONV_CTL, ctl | 8'h10);
        end else begin
            @(posedge ref_clk);
            fire_t3 <= (s == sasm_pkg::SRC_T3);
            fire_t2 <= (s == sasm_pkg::SRC_T2);
            if (s == sasm_pkg::SRC_EXT) ext_lvl <= 1'b1;
            @(posedge ref_clk);
            fire_t3 <= 1'b0;
            fire_t2 <= 1'b0;
            @(posedge ref_clk);
        end
    endtask : trig

    // Watchdog: the whole sequence needs well under 20000 cycles
    initial begin
        #400000;
        bad_count++;
        close_out();
    end

    initial begin
        logic [7:0] d, ctl, eh, el;
        logic [5:0] ex; // Expected temp, diff and positive input
        logic [7:0] ra[7] = '{8'hBA, 8'hBB, 8'hBC, 8'hE8, 8'hBE, 8'hBF, 8'h00};
        logic [7:0] rv[7] = '{8'h00, 8'h00, 8'h60, 8'h00, 8'h00, 8'h00, 8'h00};
        logic [1:0] pr;
        logic dd;
        int cnt, irq_exp;
        irq_exp = 0;
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        // Reset values, an unmapped place and read-only results
        foreach (ra[i]) rchk(ra[i], rv[i]);
        wr(8'h00, 8'hFF);
        rchk(8'h00, 8'h00);
        wr(sasm_pkg::ADDR_RES_LOW, 8'hFF);
        rchk(sasm_pkg::ADDR_RES_LOW, 8'h00);
        wr(sasm_pkg::ADDR_PAIR_CFG, 8'hFF);
        rchk(sasm_pkg::ADDR_PAIR_CFG, 8'h0F);
        wr(sasm_pkg::ADDR_CHAN_SEL, 8'hF5);
        rchk(sasm_pkg::ADDR_CHAN_SEL, 8'h05);
        // Every pair layout against every channel code
        for (int c = 0; c < 16; c++) begin
            wr(sasm_pkg::ADDR_PAIR_CFG, {4'h0, c[3:0]});
            for (int ch = 0; ch < 16; ch++) begin
                wr(sasm_pkg::ADDR_CHAN_SEL, {4'h0, ch[3:0]});
                repeat (2) @(posedge ref_clk);
                #1;
                pr = ch[2:1];
                dd = !ch[3] && c[pr];
                ex = {ch[3], dd, ch[3] ? sasm_pkg::MUX_TEMP
                    : (dd ? {1'b0, pr, 1'b0} : ch[3:0])};
                `CHK({amux_temp, amux_diff, amux_pos}, ex)
                if (dd) `CHK(amux_neg, {pr, 1'b1})
            end
        end
        // Each source in both track modes; odd code of pair 0 selected
        // Reference counted as ready: it is set up outside this block
        wr(sasm_pkg::ADDR_CONV_CFG, 8'h00);
        wr(sasm_pkg::ADDR_CHAN_SEL, 8'h01);
        for (int tm = 0; tm < 2; tm++) begin
            for (int s = 0; s < 4; s++) begin
                @(posedge ref_clk);
                irq_enable <= tm[0];
                irq_exp += tm;
                wr(sasm_pkg::ADDR_PAIR_CFG, {7'h0, s[1]});
                ctl = {1'b1, tm[0], 2'b00, s[1:0], 1'b0, s[0]};
                wr(sasm_pkg::ADDR_CONV_CTL, ctl);
                // Busy write must not start a non-software source
                if (s != 0) wr(sasm_pkg::ADDR_CONV_CTL, ctl | 8'h10);
                repeat (2) @(posedge ref_clk);
                #1;
                `CHK(hold_convert, 1'b0)
                `CHK(track_on, 1'(tm == 0 || s == 2))
                trig(s[1:0], ctl);
                @(posedge ref_clk);
                #1;
                // Pin mode converts at once in both track modes
                dd = tm != 0 && s != 2;
                `CHK({track_on, hold_convert}, {dd, !dd})
                if (s != 2 && tm != 0) begin
                    // Tracking lasts exactly three ticks at scale 000
                    @(posedge ref_clk);
                    #1;
                    `CHK({track_on, hold_convert}, 2'b10)
                    @(posedge ref_clk);
                    #1;
                    `CHK({track_on, hold_convert}, 2'b01)
                end
                for (int i = 0; i < 40; i++) begin
                    rd(sasm_pkg::ADDR_CONV_CTL, d);
                    if (d[5] === 1'b1) break;
                end
                repeat (4) @(posedge ref_clk);
                rchk(sasm_pkg::ADDR_CONV_CTL, ctl | 8'h20);
                eh = s[0] ? 8'hA5 : (s[1] ? 8'hFA : 8'h0A);
                el = s[0] ? 8'hC0 : 8'h5C;
                rchk(sasm_pkg::ADDR_RES_HIGH, eh);
                rchk(sasm_pkg::ADDR_RES_LOW, el);
                wr(sasm_pkg::ADDR_CONV_CTL, ctl);
                rchk(sasm_pkg::ADDR_CONV_CTL, ctl);
                #1;
                if (s == 2 && tm != 0) `CHK(track_on, 1'b0)
                @(posedge ref_clk);
                ext_lvl <= 1'b0;
            end
        end
        repeat (4) @(posedge ref_clk);
        `CHK(irq_seen, irq_exp)
        // Standby stops tracking, disable drops converter enable and tracking
        wr(sasm_pkg::ADDR_CONV_CTL, 8'h80);
        @(posedge ref_clk);
        chip_standby <= 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        `CHK(track_on, 1'b0)
        @(posedge ref_clk);
        chip_standby <= 1'b0;
        wr(sasm_pkg::ADDR_CONV_CTL, 8'h00);
        @(posedge ref_clk);
        #1;
        `CHK({converter_enable, track_on}, 2'b00)
        // Divider ratios, unused config bits and gain pass-through
        for (int k = 0; k < 5; k++) begin
            wr(sasm_pkg::ADDR_CONV_CFG, {k[2:0], 5'h1F});
            rchk(sasm_pkg::ADDR_CONV_CFG, {k[2:0], 5'h07});
            `CHK(pga_gain, 3'h7)
            repeat (16) @(posedge ref_clk);
            cnt = 0;
            repeat (80) begin
                @(posedge ref_clk);
                #1;
                if (sar_clk_en === 1'b1) cnt++;
            end
            `CHK(cnt, 80 >> k)
        end
        // Clearing enable in a slow conversion aborts it without done
        // Enable first: a busy write is only taken once enabled
        wr(sasm_pkg::ADDR_CONV_CTL, 8'h80);
        wr(sasm_pkg::ADDR_CONV_CTL, 8'h90);
        rchk(sasm_pkg::ADDR_CONV_CTL, 8'h90);
        wr(sasm_pkg::ADDR_CONV_CTL, 8'h00);
        repeat (40) @(posedge ref_clk);
        rchk(sasm_pkg::ADDR_CONV_CTL, 8'h00);
        close_out();
    end
endmodule : sasm_top_tb
